// [core/sicfg_pkg.sv]
// Constants, register map and device table for the configuration access unit
//
// Operation
// - Base select: off, no access, 2Eh, 15Ch.
// - Index pointer at base, read back, resets 00h.
// - Data port reaches register named by index.
// - Fixed logical device numbers per functional block.
// - Below 30h global, above banked by device.
// - Writes to missing registers or devices ignored.
// - Missing registers read 00h, 74h/75h read 04h.
// - Registers usable right after reset ends.
// - Config one bit 1 soft-resets, locked bits kept.
// - Hardware reset spares clock, wakeup, config two.
// - Retained-supply reset clears retained registers.
// - Standby reset clears wakeup, not retained ones.
// - After reset devices off; clock, wakeup run.
// - Legacy defaults restored; vendor bases are zero.
// - All sixteen address bits decoded, except bit 10 for parallel.
// - Range offset bits decoded locally, read zero.
// - Clock, serial and infrared bases below 800h.
// - Parallel base up to 3F8h, bit 10 ignored.
// - Non-legacy bases anywhere in 16-bit space.
// - Only 8-bit I/O reads, writes, DMA.
// - Nine interrupt choices, three DMA channels.
// - Logical device number register at index 07h.
// - Active only with bank bit and global enable.
`default_nettype none
package sicfg_pkg;
  localparam int NB = 8;
  localparam logic [1:0]  SICFG_SEL_OFF      = 2'h0;
  localparam logic [1:0]  SICFG_SEL_NOCFG    = 2'h1;
  localparam logic [1:0]  SICFG_SEL_BASE_ONE = 2'h2;
  localparam logic [1:0]  SICFG_SEL_BASE_TWO = 2'h3;
  localparam logic [15:0] SICFG_BASE_ONE     = 16'h002e;
  localparam logic [15:0] SICFG_BASE_TWO     = 16'h015c;
  localparam logic [7:0]  SICFG_IDX_LDN      = 8'h07;
  localparam logic [7:0]  SICFG_IDX_ID       = 8'h20;
  localparam logic [7:0]  SICFG_IDX_CFG1     = 8'h21;
  localparam logic [7:0]  SICFG_IDX_CFG2     = 8'h22;
  localparam logic [7:0]  SICFG_IDX_REV      = 8'h27;
  localparam logic [7:0]  SICFG_IDX_ACT      = 8'h30;
  localparam logic [7:0]  SICFG_IDX_BASE_HI  = 8'h60;
  localparam logic [7:0]  SICFG_IDX_BASE_LO  = 8'h61;
  localparam logic [7:0]  SICFG_IDX_IRQ_NUM  = 8'h70;
  localparam logic [7:0]  SICFG_IDX_IRQ_TYPE = 8'h71;
  localparam logic [7:0]  SICFG_IDX_DMA0     = 8'h74;
  localparam logic [7:0]  SICFG_IDX_DMA1     = 8'h75;
  localparam logic [7:0]  SICFG_IDX_VEND     = 8'hf0;
  // Identity values are arbitrary
  localparam logic [7:0]  SICFG_CHIP_ID      = 8'h5a;
  localparam logic [7:0]  SICFG_REV_ID       = 8'h01;
  localparam logic [7:0]  SICFG_INDEX_RST    = 8'h00;
  localparam logic [7:0]  SICFG_LDN_RST      = 8'h00;
  localparam logic [7:0]  SICFG_CFG1_RST     = 8'h01;
  localparam logic [7:0]  SICFG_CFG2_RST     = 8'h02;
  localparam logic [7:0]  SICFG_READ_EMPTY   = 8'h00;
  localparam logic [7:0]  SICFG_READ_NODMA   = 8'h04;
  localparam logic [2:0]  SICFG_DMA_NONE     = 3'h4;
  localparam logic [3:0]  SICFG_IRQ_NONE     = 4'h0;
  localparam logic [1:0]  SICFG_IRQ_TYPE_RST = 2'h2;
  localparam logic [7:0]  SICFG_VEND_RST     = 8'h00;
  localparam logic [25:0] SICFG_PIN_IDLE     = 26'h3000000;
  localparam int          SICFG_ENABLE_BIT   = 0;
  localparam int          SICFG_SWRST_BIT    = 1;
  localparam int          SICFG_LOCK_BIT     = 5;
  localparam logic [7:0]  SICFG_SCRATCH_MASK = 8'hc0;
  localparam logic [7:0]  SICFG_LOCK_MASK    = 8'h20;
  localparam logic [7:0]  SICFG_SWRST_MASK   = 8'h02;
  // Banks: clock, wakeup, infrared, serial 1, two-wire 1/2, parallel, serial 2
  localparam int SICFG_BANK_RTC  = 0;
  localparam int SICFG_BANK_WAKE = 1;
  localparam int SICFG_BANK_SP1  = 3;
  localparam int SICFG_BANK_PP   = 6;
  localparam logic [7:0] SICFG_BANK_LDN [NB] =
    '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h06, 8'h07, 8'h08};
  localparam logic [15:0] SICFG_OFFSET_MASK [NB] =
    '{16'h0001, 16'h000f, 16'h0007, 16'h0007, 16'h0007, 16'h0007, 16'h0007, 16'h0007};
  localparam logic [15:0] SICFG_LIMIT_MASK [NB] =
    '{16'h07ff, 16'hffff, 16'h07ff, 16'h07ff, 16'hffff, 16'hffff, 16'h03ff, 16'h07ff};
  localparam logic [15:0] SICFG_DECODE_IGNORE [NB] =
    '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0400, 16'h0000};
  localparam logic [15:0] SICFG_BASE_RST [NB] =
    '{16'h0070, 16'h0000, 16'h02e8, 16'h03f8, 16'h0000, 16'h0000, 16'h0378, 16'h02f8};
  localparam logic [3:0] SICFG_IRQ_RST [NB] =
    '{4'h8, 4'h0, 4'h3, 4'h4, 4'h0, 4'h0, 4'h7, 4'h3};
  localparam logic [7:0]  SICFG_KEEP_BANKS   = 8'b0000_0011;
  localparam logic [7:0]  SICFG_DMA0_BANKS   = 8'b0100_0100;
  localparam logic [7:0]  SICFG_DMA1_BANKS   = 8'b0000_0100;
  localparam logic [15:0] SICFG_IRQ_LEGAL    = 16'h0ff8;
  localparam logic [7:0]  SICFG_DMA_LEGAL    = 8'h0e;
endpackage
`default_nettype wire

// [core/sicfg_match_if.sv]
// Address range compare signals between the unit and a range matcher
`timescale 1ns/1ps
`default_nettype none
interface sicfg_match_if;
  logic [15:0] addr;
  logic [15:0] base;
  logic [15:0] careMask;
  logic        hit;
  modport matcher (input addr, input base, input careMask, output hit);
  modport owner   (output addr, output base, output careMask, input hit);
endinterface
`default_nettype wire

// [core/sicfg_range_match.sv]
// Full 16-bit range match of a host address against one block base
`timescale 1ns/1ps
`default_nettype none
module sicfg_range_match (
  sicfg_match_if.matcher port
);
  logic [15:0] diff;

  // Offset bits are left to the block itself
  assign diff     = (port.addr ^ port.base) & port.careMask;
  assign port.hit = (diff == 16'h0000);
endmodule
`default_nettype wire

// [core/sicfg_config_unit.sv]
// Configuration access unit: index/data port, global and banked registers
`timescale 1ns/1ps
`default_nettype none
module sicfg_config_unit
  import sicfg_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                retainedPorRst,
  input  wire logic                standbyPorRst,
  input  wire logic [1:0]          configBaseSelect,
  input  wire logic [15:0]         ioAddr,
  input  wire logic [7:0]          ioDataIn,
  input  wire logic                ioRdN,
  input  wire logic                ioWrN,
  output logic      [7:0]          ioDataOut,
  output logic                     ioDataOe,
  output logic      [NB-1:0]       devRun,
  output logic      [NB-1:0]       devSelect,
  output logic      [NB-1:0][15:0] devBase,
  output logic      [NB-1:0][3:0]  devIrqNum,
  output logic      [NB-1:0][1:0]  devIrqType,
  output logic      [NB-1:0][2:0]  devDmaZero,
  output logic      [NB-1:0][2:0]  devDmaOne,
  output logic      [NB-1:0][7:0]  devVendor,
  output logic      [7:0]          globalConfigTwo
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic cfg_port(input logic [1:0] sel,
                                    input logic [15:0] addr,
                                    input logic dataPort);
    logic [15:0] base;
    base = (sel == SICFG_SEL_BASE_TWO) ? SICFG_BASE_TWO : SICFG_BASE_ONE;
    cfg_port = ((sel == SICFG_SEL_BASE_ONE) || (sel == SICFG_SEL_BASE_TWO)) &&
               (addr == (base | {15'h0000, dataPort}));
  endfunction

  // Returns {valid, bank}; unassigned numbers give valid low
  function automatic logic [3:0] bank_of(input logic [7:0] logical_device_number);
    bank_of = 4'h0;
    for (int i = 0; i < NB; i++) begin
      if (logical_device_number == SICFG_BANK_LDN[i]) begin
        bank_of = {1'b1, 3'(i)};
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Host pin synchronisers

  logic [25:0] pinS1Q;
  logic [25:0] pinS2Q;
  logic [15:0] addrS;
  logic [7:0]  dataS;
  logic        rdS;
  logic        wrS;
  logic        wrLowQ;
  logic [15:0] capAddrQ;
  logic [7:0]  capDataQ;
  logic        wrEv;

  always_ff @(posedge clk) begin
    if (rst) begin
      pinS1Q <= SICFG_PIN_IDLE;
      pinS2Q <= SICFG_PIN_IDLE;
    end else begin
      pinS1Q <= {ioWrN, ioRdN, ioDataIn, ioAddr};
      pinS2Q <= pinS1Q;
    end
  end

  assign addrS = pinS2Q[15:0];
  assign dataS = pinS2Q[23:16];
  assign rdS   = pinS2Q[24];
  assign wrS   = pinS2Q[25];

  // Address and data are held from the last low cycle of the strobe,
  // so a write commits on its trailing edge with settled values
  always_ff @(posedge clk) begin
    if (rst) begin
      wrLowQ   <= 1'b0;
      capAddrQ <= 16'h0000;
      capDataQ <= 8'h00;
    end else begin
      wrLowQ <= !wrS;
      if (!wrS) begin
        capAddrQ <= addrS;
        capDataQ <= dataS;
      end
    end
  end

  assign wrEv = wrLowQ && wrS;

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  logic       modOn;
  logic       wrIdx;
  logic       wrData;
  logic       rdIsIndex;
  logic       rdIsData;
  logic       rdSel;
  logic [7:0] indexQ;
  logic [7:0] ldnQ;
  logic [7:0] cfg1Q;
  logic [7:0] cfg2Q;
  logic       swRstQ;
  logic [3:0] bankInfo;
  logic       bankValid;
  logic [2:0] bankSel;
  logic       idxBanked;
  logic       wrLdn;
  logic       wrCfg1;
  logic       wrCfg2;
  logic       wrBank;
  logic       locked;
  logic [7:0] keepMask;
  logic [7:0] cfg1Wr;
  logic [7:0] cfg1SwRst;
  logic [3:0] irqWr;
  logic [2:0] dmaWr;

  assign modOn     = configBaseSelect != SICFG_SEL_OFF;
  assign wrIdx     = wrEv && cfg_port(configBaseSelect, capAddrQ, 1'b0);
  assign wrData    = wrEv && cfg_port(configBaseSelect, capAddrQ, 1'b1);
  assign rdIsIndex = cfg_port(configBaseSelect, addrS, 1'b0);
  assign rdIsData  = cfg_port(configBaseSelect, addrS, 1'b1);
  assign rdSel     = !rdS && (rdIsIndex || rdIsData);

  assign bankInfo  = bank_of(ldnQ);
  assign bankValid = bankInfo[3];
  assign bankSel   = bankInfo[2:0];
  assign idxBanked = indexQ >= SICFG_IDX_ACT;

  assign wrLdn  = wrData && (indexQ == SICFG_IDX_LDN);
  assign wrCfg1 = wrData && (indexQ == SICFG_IDX_CFG1);
  assign wrCfg2 = wrData && (indexQ == SICFG_IDX_CFG2);
  assign wrBank = wrData && idxBanked && bankValid;

  // Scratch bits freeze once locked; the lock itself is sticky
  assign locked    = cfg1Q[SICFG_LOCK_BIT];
  assign keepMask  = locked ? (SICFG_LOCK_MASK | SICFG_SCRATCH_MASK) : 8'h00;
  assign cfg1Wr    = (capDataQ & ~SICFG_SWRST_MASK & ~keepMask) | (cfg1Q & keepMask);
  assign cfg1SwRst = (SICFG_CFG1_RST & ~keepMask) | (cfg1Q & keepMask);

  // Illegal choices fall back to no interrupt and no DMA channel
  assign irqWr = SICFG_IRQ_LEGAL[capDataQ[3:0]] ? capDataQ[3:0] : SICFG_IRQ_NONE;
  assign dmaWr = SICFG_DMA_LEGAL[capDataQ[2:0]] ? capDataQ[2:0] : SICFG_DMA_NONE;

  ////////////////////////////////////////////////////////////////////////////
  // Global registers

  // No unlock step: writes land on the first strobe after reset
  always_ff @(posedge clk) begin
    if (rst) begin
      indexQ <= SICFG_INDEX_RST;
      ldnQ   <= SICFG_LDN_RST;
      cfg1Q  <= SICFG_CFG1_RST;
      swRstQ <= 1'b0;
    end else begin
      swRstQ <= wrCfg1 && capDataQ[SICFG_SWRST_BIT];
      if (wrIdx) begin
        indexQ <= capDataQ;
      end
      if (swRstQ) begin
        ldnQ  <= SICFG_LDN_RST;
        cfg1Q <= cfg1SwRst;
      end else begin
        if (wrLdn) begin
          ldnQ <= capDataQ;
        end
        if (wrCfg1) begin
          cfg1Q <= cfg1Wr;
        end
      end
    end
  end

  // Retained register: hardware reset leaves it alone
  always_ff @(posedge clk) begin
    if (retainedPorRst) begin
      cfg2Q <= SICFG_CFG2_RST;
    end else if (wrCfg2) begin
      cfg2Q <= capDataQ;
    end
  end

  assign globalConfigTwo = cfg2Q;

  ////////////////////////////////////////////////////////////////////////////
  // Logical device banks

  logic        actQ     [NB];
  logic [15:0] baseQ    [NB];
  logic [3:0]  irqNumQ  [NB];
  logic [1:0]  irqTypeQ [NB];
  logic [2:0]  dma0Q    [NB];
  logic [2:0]  dma1Q    [NB];
  logic [7:0]  vendQ    [NB];

  for (genvar b = 0; b < NB; b++) begin : g_bank
    logic        hit;
    logic        clrStd;
    logic        clrVend;
    logic [15:0] wrMask;
    sicfg_match_if mIf ();

    assign hit = wrBank && (bankSel == 3'(b));
    // Clock and wakeup banks only follow their own supply resets
    assign clrStd = SICFG_KEEP_BANKS[b] ?
                    (retainedPorRst || (standbyPorRst && (b == SICFG_BANK_WAKE))) :
                    (rst || swRstQ);
    assign clrVend = (b == SICFG_BANK_WAKE) ? retainedPorRst : clrStd;
    assign wrMask  = SICFG_LIMIT_MASK[b] & ~SICFG_OFFSET_MASK[b];

    always_ff @(posedge clk) begin
      if (clrStd) begin
        actQ[b]     <= 1'b0;
        baseQ[b]    <= SICFG_BASE_RST[b];
        irqNumQ[b]  <= SICFG_IRQ_RST[b];
        irqTypeQ[b] <= SICFG_IRQ_TYPE_RST;
        dma0Q[b]    <= SICFG_DMA_NONE;
        dma1Q[b]    <= SICFG_DMA_NONE;
      end else if (hit) begin
        if (indexQ == SICFG_IDX_ACT) begin
          actQ[b] <= capDataQ[0];
        end
        if (indexQ == SICFG_IDX_BASE_HI) begin
          baseQ[b][15:8] <= capDataQ & wrMask[15:8];
        end
        if (indexQ == SICFG_IDX_BASE_LO) begin
          baseQ[b][7:0] <= capDataQ & wrMask[7:0];
        end
        if (indexQ == SICFG_IDX_IRQ_NUM) begin
          irqNumQ[b] <= irqWr;
        end
        if (indexQ == SICFG_IDX_IRQ_TYPE) begin
          irqTypeQ[b] <= capDataQ[1:0];
        end
        if ((indexQ == SICFG_IDX_DMA0) && SICFG_DMA0_BANKS[b]) begin
          dma0Q[b] <= dmaWr;
        end
        if ((indexQ == SICFG_IDX_DMA1) && SICFG_DMA1_BANKS[b]) begin
          dma1Q[b] <= dmaWr;
        end
      end
    end

    always_ff @(posedge clk) begin
      if (clrVend) begin
        vendQ[b] <= SICFG_VEND_RST;
      end else if (hit && (indexQ == SICFG_IDX_VEND)) begin
        vendQ[b] <= capDataQ;
      end
    end

    assign mIf.addr     = addrS;
    assign mIf.base     = baseQ[b];
    assign mIf.careMask = ~(SICFG_OFFSET_MASK[b] | SICFG_DECODE_IGNORE[b]);
    sicfg_range_match u_match (
      .port (mIf)
    );

    // Clock and wakeup keep running, yet their registers need activation
    assign devRun[b]    = modOn && (SICFG_KEEP_BANKS[b] ||
                          (actQ[b] && cfg1Q[SICFG_ENABLE_BIT]));
    assign devSelect[b] = modOn && actQ[b] && cfg1Q[SICFG_ENABLE_BIT] &&
                          mIf.hit && (!rdS || !wrS);
    assign devBase[b]    = baseQ[b];
    assign devIrqNum[b]  = irqNumQ[b];
    assign devIrqType[b] = irqTypeQ[b];
    assign devDmaZero[b] = dma0Q[b];
    assign devDmaOne[b]  = dma1Q[b];
    assign devVendor[b]  = vendQ[b];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  logic [7:0] dataMux;
  logic [7:0] rdDataQ;

  always_comb begin
    dataMux = SICFG_READ_EMPTY;
    unique case (indexQ)
      SICFG_IDX_LDN:      dataMux = ldnQ;
      SICFG_IDX_ID:       dataMux = SICFG_CHIP_ID;
      SICFG_IDX_CFG1:     dataMux = cfg1Q;
      SICFG_IDX_CFG2:     dataMux = cfg2Q;
      SICFG_IDX_REV:      dataMux = SICFG_REV_ID;
      SICFG_IDX_ACT:      dataMux = bankValid ? {7'h00, actQ[bankSel]} : SICFG_READ_EMPTY;
      SICFG_IDX_BASE_HI:  dataMux = bankValid ? baseQ[bankSel][15:8] : SICFG_READ_EMPTY;
      SICFG_IDX_BASE_LO:  dataMux = bankValid ? baseQ[bankSel][7:0] : SICFG_READ_EMPTY;
      SICFG_IDX_IRQ_NUM:  dataMux = bankValid ? {4'h0, irqNumQ[bankSel]} : SICFG_READ_EMPTY;
      SICFG_IDX_IRQ_TYPE: dataMux = bankValid ? {6'h00, irqTypeQ[bankSel]} : SICFG_READ_EMPTY;
      SICFG_IDX_DMA0:     dataMux = (bankValid && SICFG_DMA0_BANKS[bankSel]) ?
                                    {5'h00, dma0Q[bankSel]} : SICFG_READ_NODMA;
      SICFG_IDX_DMA1:     dataMux = (bankValid && SICFG_DMA1_BANKS[bankSel]) ?
                                    {5'h00, dma1Q[bankSel]} : SICFG_READ_NODMA;
      SICFG_IDX_VEND:     dataMux = bankValid ? vendQ[bankSel] : SICFG_READ_EMPTY;
      default:            dataMux = SICFG_READ_EMPTY;
    endcase
  end

  // Reads have no side effects, so the data is refreshed every cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      rdDataQ <= 8'h00;
    end else begin
      rdDataQ <= rdIsData ? dataMux : indexQ;
    end
  end

  assign ioDataOut = rdDataQ;
  assign ioDataOe  = rdSel;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  AST_CFG_OFF: assert property (
    (configBaseSelect == SICFG_SEL_OFF || configBaseSelect == SICFG_SEL_NOCFG) |-> !ioDataOe)
    else $error("config port answered while disabled");
  AST_BASE_TWO: assert property (
    (configBaseSelect == SICFG_SEL_BASE_TWO && !rdS && addrS == 16'h015d) |-> ioDataOe)
    else $error("second data port not answering");
  AST_INDEX_WRITE: assert property (
    wrIdx |=> (indexQ == $past(capDataQ)) ##1 (rdIsIndex -> rdDataQ == $past(indexQ)))
    else $error("index pointer not written or read back");
  AST_LDN_READBACK: assert property (
    (wrLdn && !swRstQ) |=> (ldnQ == $past(capDataQ)))
    else $error("device number not stored");
  AST_NODMA_READ: assert property (
    (rdIsData && indexQ == SICFG_IDX_DMA1 && !(bankValid && SICFG_DMA1_BANKS[bankSel]))
    |=> rdDataQ == SICFG_READ_NODMA)
    else $error("missing DMA register did not read 04h");
  AST_IGNORE_BAD_LDN: assert property (
    (wrData && idxBanked && !bankValid && !swRstQ) |=> (devBase == $past(devBase)))
    else $error("write to unassigned device changed a bank");
  AST_NO_AUTOINC: assert property (
    (wrData || (rdSel && rdIsData)) |=> $stable(indexQ) [*2])
    else $error("index moved on a data access");
  AST_ENABLE_GATE: assert property (
    devRun[SICFG_BANK_PP] |-> (cfg1Q[SICFG_ENABLE_BIT] && actQ[SICFG_BANK_PP]))
    else $error("parallel block running without both enables");
  AST_LOCK_HOLDS: assert property (
    (swRstQ && locked) |=> (locked && (cfg1Q & SICFG_SCRATCH_MASK) ==
                            ($past(cfg1Q) & SICFG_SCRATCH_MASK)))
    else $error("soft reset changed locked bits");
  AST_SOFT_DEFAULTS: assert property (
    swRstQ |=> (!actQ[SICFG_BANK_PP] && devBase[SICFG_BANK_PP] == SICFG_BASE_RST[SICFG_BANK_PP]))
    else $error("soft reset did not restore defaults");
  AST_ALIGN: assert property (
    (devBase[SICFG_BANK_SP1] & (SICFG_OFFSET_MASK[SICFG_BANK_SP1] | 16'hf800)) == 16'h0000)
    else $error("serial base outside its range or unaligned");

  COV_INDEX_WRITE: cover property (wrIdx);
  COV_BANK_WRITE: cover property (wrBank ##[1:200] (rdSel && rdIsData));
  COV_SOFT_RESET: cover property (swRstQ);
  COV_DEV_SELECT: cover property (|devSelect);

endmodule
`default_nettype wire

// [bench/sicfg_host_model.sv]
// Host side bus master model issuing byte-wide I/O reads and writes
`timescale 1ns/1ps
`default_nettype none
module sicfg_host_model (
  input  wire logic        clk,
  input  wire logic [7:0]  ioDataOut,
  input  wire logic        ioDataOe,
  output logic      [15:0] ioAddr,
  output logic      [7:0]  ioDataIn,
  output logic             ioRdN,
  output logic             ioWrN
);
  initial begin
    ioAddr = 16'hffff;
    ioDataIn = 8'hff;
    ioRdN = 1'b1;
    ioWrN = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Only single byte I/O cycles; write strobe low 4 and high 5 cycles, read strobe low 5, over the minimum of 3
  task automatic io_write(input logic [15:0] a, input logic [7:0] d);
    ioAddr <= a;
    ioDataIn <= d;
    ioWrN <= 1'b0;
    repeat (4) @(posedge clk);
    ioWrN <= 1'b1;
    repeat (5) @(posedge clk);
    // Released bus shows the inverse so stale data cannot pass
    ioDataIn <= ~d;
    ioAddr <= ~a;
    // One idle edge so a following call never re-drives a pin in this step
    @(posedge clk);
  endtask
  task automatic io_read(input logic [15:0] a, output logic [7:0] d, output logic oe);
    ioAddr <= a;
    ioRdN <= 1'b0;
    repeat (5) @(posedge clk);
    d = ioDataOut;
    oe = ioDataOe;
    ioRdN <= 1'b1;
    repeat (4) @(posedge clk);
    ioAddr <= ~a;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// [bench/test_superio_config_index_data.sv]
// Self-checking bench of the configuration access unit
`timescale 1ns/1ps
`default_nettype none
module test_superio_config_index_data;
  import sicfg_pkg::*;
  logic clk, rst, retainedPorRst, standbyPorRst, oe;
  logic [1:0] configBaseSelect;
  logic [15:0] ioAddr, cfgBase, v16;
  logic [7:0] ioDataIn, ioDataOut, r, v;
  logic ioRdN, ioWrN, ioDataOe;
  logic [NB-1:0] devRun, devSelect;
  logic [NB-1:0][15:0] devBase;
  logic [NB-1:0][3:0] devIrqNum;
  logic [NB-1:0][1:0] devIrqType;
  logic [NB-1:0][2:0] devDmaZero, devDmaOne;
  logic [NB-1:0][7:0] devVendor;
  logic [7:0] cfgTwo;
  int error_cnt, n_tests, b, s;
  int baseM [NB];
  sicfg_config_unit u_dut (.clk(clk), .rst(rst), .retainedPorRst(retainedPorRst),
    .standbyPorRst(standbyPorRst), .configBaseSelect(configBaseSelect), .ioAddr(ioAddr),
    .ioDataIn(ioDataIn), .ioRdN(ioRdN), .ioWrN(ioWrN), .ioDataOut(ioDataOut),
    .ioDataOe(ioDataOe), .devRun(devRun), .devSelect(devSelect), .devBase(devBase),
    .devIrqNum(devIrqNum), .devIrqType(devIrqType), .devDmaZero(devDmaZero),
    .devDmaOne(devDmaOne), .devVendor(devVendor), .globalConfigTwo(cfgTwo));
  sicfg_host_model u_host (.clk(clk), .ioDataOut(ioDataOut), .ioDataOe(ioDataOe),
    .ioAddr(ioAddr), .ioDataIn(ioDataIn), .ioRdN(ioRdN), .ioWrN(ioWrN));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    u_host.io_write(cfgBase, idx);
    u_host.io_write(cfgBase + 16'h0001, d);
  endtask
  task automatic rd(input logic [7:0] idx, output logic [7:0] d);
    u_host.io_write(cfgBase, idx);
    u_host.io_read(cfgBase + 16'h0001, d, oe);
  endtask
  task automatic pulse(input int which);
    if (which == 0) rst <= 1'b1;
    else if (which == 1) standbyPorRst <= 1'b1;
    else retainedPorRst <= 1'b1;
    @(posedge clk);
    {rst, standbyPorRst, retainedPorRst} <= 3'h0;
    repeat (2) @(posedge clk);
  endtask
  task automatic tally_and_finish;
    $display("errors=%0d comparisons=%0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst, retainedPorRst, standbyPorRst} = 3'h7;
    configBaseSelect = SICFG_SEL_BASE_ONE;
    cfgBase = SICFG_BASE_ONE;
    error_cnt = 0;
    n_tests = 0;
    void'($urandom(32'hb2b8));
    repeat (6) @(posedge clk);
    {rst, retainedPorRst, standbyPorRst} <= 3'h0;
    @(posedge clk);
    u_host.io_read(cfgBase, r, oe); chk8(r, 8'h00);
    rd(SICFG_IDX_CFG1, r); chk8(r, SICFG_CFG1_RST);
    rd(SICFG_IDX_LDN, r); chk8(r, 8'h00);
    for (b = 0; b < NB; b++) begin
      baseM[b] = SICFG_BASE_RST[b];
      chk16(devBase[b], SICFG_BASE_RST[b]);
    end
    for (s = 2; s < 4; s++) begin
      configBaseSelect <= 2'(s);
      cfgBase = (s == 2) ? SICFG_BASE_ONE : SICFG_BASE_TWO;
      @(posedge clk);
      v = 8'($urandom);
      u_host.io_write(cfgBase, v);
      u_host.io_write(cfgBase | 16'h1000, ~v);
      u_host.io_read(cfgBase, r, oe); chk8(r, v);
      rd(SICFG_IDX_ID, r); chk8(r, SICFG_CHIP_ID);
    end
    configBaseSelect <= SICFG_SEL_NOCFG;
    @(posedge clk);
    u_host.io_read(cfgBase, r, oe); chk8({7'h0, oe}, 8'h00);
    configBaseSelect <= SICFG_SEL_BASE_ONE;
    cfgBase = SICFG_BASE_ONE;
    @(posedge clk);
    // Every bank: base written in two halves, alignment and limits applied
    for (b = 0; b < NB; b++) begin
      v16 = 16'($urandom);
      wr(SICFG_IDX_LDN, SICFG_BANK_LDN[b]);
      wr(SICFG_IDX_BASE_HI, v16[15:8]);
      wr(SICFG_IDX_BASE_LO, v16[7:0]);
      baseM[b] = v16 & ~SICFG_OFFSET_MASK[b] & SICFG_LIMIT_MASK[b];
      chk16(devBase[b], 16'(baseM[b]));
      rd(SICFG_IDX_BASE_LO, r); chk8(r, 8'(baseM[b]));
      u_host.io_read(cfgBase + 16'h0001, r, oe); chk8(r, 8'(baseM[b]));
      rd(SICFG_IDX_DMA1, r); chk8(r, SICFG_READ_NODMA);
    end
    wr(SICFG_IDX_LDN, 8'h04);
    wr(SICFG_IDX_BASE_HI, 8'h12);
    rd(SICFG_IDX_BASE_HI, r); chk8(r, 8'h00);
    rd(8'h50, r); chk8(r, SICFG_READ_EMPTY);
    for (b = 0; b < NB; b++) chk16(devBase[b], 16'(baseM[b]));
    // Parallel bank resources: interrupt and channel choices, vendor byte
    v = 8'($urandom);
    wr(SICFG_IDX_LDN, 8'h07);
    wr(SICFG_IDX_IRQ_NUM, v);
    r = (v[3:0] >= 4'h3 && v[3:0] <= 4'hb) ? {4'h0, v[3:0]} : {4'h0, SICFG_IRQ_NONE};
    chk8({4'h0, devIrqNum[SICFG_BANK_PP]}, r);
    wr(SICFG_IDX_IRQ_TYPE, v);
    chk8({6'h00, devIrqType[SICFG_BANK_PP]}, {6'h00, v[1:0]});
    wr(SICFG_IDX_DMA0, v);
    r = (v[2:0] >= 3'h1 && v[2:0] <= 3'h3) ? {5'h00, v[2:0]} : SICFG_READ_NODMA;
    chk8({5'h00, devDmaZero[SICFG_BANK_PP]}, r);
    wr(SICFG_IDX_DMA1, 8'h01);
    chk8({5'h00, devDmaOne[SICFG_BANK_PP]}, SICFG_READ_NODMA);
    wr(SICFG_IDX_VEND, ~v);
    chk8(devVendor[SICFG_BANK_PP], ~v);
    wr(SICFG_IDX_CFG2, v);
    chk8(cfgTwo, v);
    wr(SICFG_IDX_LDN, 8'h03);
    wr(SICFG_IDX_ACT, 8'h01);
    chk8({7'h0, devRun[SICFG_BANK_SP1]}, 8'h01);
    // Select stands while the strobe is low; an alias in bit 12 must miss
    for (s = 0; s < 2; s++) begin
      fork
        u_host.io_read(16'(baseM[SICFG_BANK_SP1]) ^ 16'(s << 12), r, oe);
        begin
          repeat (4) @(posedge clk);
          chk8({7'h0, devSelect[SICFG_BANK_SP1]}, 8'(s == 0));
        end
      join
    end
    wr(SICFG_IDX_CFG1, 8'h00);
    chk8({7'h0, devRun[SICFG_BANK_SP1]}, 8'h00);
    wr(SICFG_IDX_CFG1, 8'h03);
    repeat (3) @(posedge clk);
    chk16(devBase[SICFG_BANK_SP1], SICFG_BASE_RST[SICFG_BANK_SP1]);
    chk16(devBase[SICFG_BANK_RTC], 16'(baseM[SICFG_BANK_RTC]));
    rd(SICFG_IDX_LDN, r); chk8(r, 8'h00);
    rd(SICFG_IDX_CFG1, r); chk8(r, SICFG_CFG1_RST);
    // Lock with scratch set, then soft reset: locked bits survive
    wr(SICFG_IDX_CFG1, 8'he1);
    wr(SICFG_IDX_CFG1, 8'h03);
    repeat (3) @(posedge clk);
    rd(SICFG_IDX_CFG1, r); chk8(r, 8'he1);
    wr(SICFG_IDX_ACT, 8'h01);
    pulse(0);
    chk16(devBase[SICFG_BANK_RTC], 16'(baseM[SICFG_BANK_RTC]));
    chk16(devBase[SICFG_BANK_PP], SICFG_BASE_RST[SICFG_BANK_PP]);
    chk8({6'h0, devRun[SICFG_BANK_SP1], devRun[SICFG_BANK_RTC]}, 8'h01);
    chk8(cfgTwo, v);
    rd(SICFG_IDX_CFG1, r); chk8(r, SICFG_CFG1_RST);
    pulse(1);
    chk16(devBase[SICFG_BANK_WAKE], SICFG_BASE_RST[SICFG_BANK_WAKE]);
    chk16(devBase[SICFG_BANK_RTC], 16'(baseM[SICFG_BANK_RTC]));
    pulse(2);
    chk16(devBase[SICFG_BANK_RTC], SICFG_BASE_RST[SICFG_BANK_RTC]);
    chk8(cfgTwo, SICFG_CFG2_RST);
    tally_and_finish();
  end
endmodule
`default_nettype wire
